// file: rtl/bcis_core.sv
/*
 * bcis_core: executes a subset of an 8-bit baseline instruction set,
 * issued one word at a time by software over AXI4-Lite.
 * Assumes: one clock, synchronous active-low reset, a single bus
 * master with at most one write and one read under way.
 */
// Chosen here: register access over AXI4-Lite and the placing of the registers.
// Contract
// - acc AND file 0..31 goes to acc (d=0) or file (d=1), only Z moves.
// - skip-if-zero tests file bit 0..7, skips when it is 0, flags kept.
// - skip-if-one tests the chosen bit, skips when it is 1, flags kept.
// - a taken skip drops the prefetched word, runs a no-op, two cycles.
// - clear-accumulator loads 00h and sets Z, nothing else.
// - a call first pushes program counter plus 1 on the stack.
// - a call puts literal in pc 7:0, status 6:5 in pc 10:9, zero in pc 8.
// - a call takes two cycles and leaves the flags alone.
// - a watchdog kick zeroes the counter, sets both low-active flags.
// - the kick zeroes the prescaler only while it feeds the watchdog.
// - a bit-test skip takes one cycle when not taken and two when taken.
`timescale 1ns/1ps
`default_nettype none
module bcis_core #(
   parameter int ADDR_W      = 8,
   parameter int STACK_DEPTH = 2
) (
   input  wire logic              aclk,
   input  wire logic              aresetn,
   input  wire logic [ADDR_W-1:0] s_axi_awaddr,
   input  wire logic [2:0]        s_axi_awprot,
   input  wire logic              s_axi_awvalid,
   output logic                   s_axi_awready,
   input  wire logic [31:0]       s_axi_wdata,
   input  wire logic [3:0]        s_axi_wstrb,
   input  wire logic              s_axi_wvalid,
   output logic                   s_axi_wready,
   output logic [1:0]             s_axi_bresp,
   output logic                   s_axi_bvalid,
   input  wire logic              s_axi_bready,
   input  wire logic [ADDR_W-1:0] s_axi_araddr,
   input  wire logic [2:0]        s_axi_arprot,
   input  wire logic              s_axi_arvalid,
   output logic                   s_axi_arready,
   output logic [31:0]            s_axi_rdata,
   output logic [1:0]             s_axi_rresp,
   output logic                   s_axi_rvalid,
   input  wire logic              s_axi_rready
);
   localparam int PW = bcis_pkg::PC_W;

   function automatic logic [31:0] strb_merge(input logic [31:0] old,
                                              input logic [31:0] nw,
                                              input logic [3:0]  strb);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) r[i*8 +: 8] = nw[i*8 +: 8];
      end
      return r;
   endfunction

   function automatic logic is_file(input logic [ADDR_W-1:0] a);
      return a[bcis_pkg::FILE_MSB] && (a[1:0] == 2'h0);
   endfunction

   ////////////////////////////////////////////////////////////////////
   // state
   bcis_pkg::bcis_state_t state_ff, nxt_state;
   logic [11:0]   instr_ff;
   logic [7:0]    acc_ff, nxt_acc;
   logic [7:0]    status_ff, nxt_status;
   logic [PW-1:0] pc_ff, nxt_pc;
   logic [7:0]    option_ff;
   logic [7:0]    wdt_ff, psc_ff;
   logic          bad_ff;
   logic [7:0]    file_ff [bcis_pkg::NFILE];

   logic              aw_held_ff, w_held_ff;
   logic [ADDR_W-1:0] awaddr_ff;
   logic [31:0]       wdata_ff;
   logic [3:0]        wstrb_ff;
   logic              bvalid_ff, rvalid_ff;
   logic [1:0]        bresp_ff, rresp_ff;
   logic [31:0]       rdata_ff;

   bcis_pkg::bcis_dec_t dec;
   logic [PW-1:0]       stack_top;

   ////////////////////////////////////////////////////////////////////
   // write channel acceptance
   assign s_axi_awready = !aw_held_ff && !bvalid_ff;
   assign s_axi_wready  = !w_held_ff && !bvalid_ff;
   assign s_axi_bvalid  = bvalid_ff;
   assign s_axi_bresp   = bresp_ff;

   wire aw_take = s_axi_awvalid && s_axi_awready;
   wire w_take  = s_axi_wvalid && s_axi_wready;
   wire wr_do   = (aw_held_ff || aw_take) && (w_held_ff || w_take);
   wire [ADDR_W-1:0] waddr = aw_held_ff ? awaddr_ff : s_axi_awaddr;
   wire [31:0]       wdat  = w_held_ff ? wdata_ff : s_axi_wdata;
   wire [3:0]        wstb  = w_held_ff ? wstrb_ff : s_axi_wstrb;

   wire busy      = state_ff != bcis_pkg::S_IDLE;
   wire hw_instr  = waddr == bcis_pkg::A_INSTR;
   wire hw_acc    = waddr == bcis_pkg::A_ACC;
   wire hw_status = waddr == bcis_pkg::A_STATUS;
   wire hw_pc     = waddr == bcis_pkg::A_PC;
   wire hw_cstat  = waddr == bcis_pkg::A_CSTAT;
   wire hw_option = waddr == bcis_pkg::A_OPTION;
   wire hw_file   = is_file(waddr);
   wire hw_any    = hw_instr || hw_acc || hw_status || hw_pc ||
                    hw_cstat || hw_option || hw_file;
   // writes are refused while an instruction is in flight
   wire wr_ok     = wr_do && hw_any && !busy;
   wire instr_go  = wr_ok && hw_instr;

   wire [31:0] m_instr  = strb_merge({20'h0, instr_ff}, wdat, wstb);
   wire [31:0] m_acc    = strb_merge({24'h0, acc_ff}, wdat, wstb);
   wire [31:0] m_status = strb_merge({24'h0, status_ff}, wdat, wstb);
   wire [31:0] m_pc     = strb_merge({21'h0, pc_ff}, wdat, wstb);
   wire [31:0] m_option = strb_merge({24'h0, option_ff}, wdat, wstb);
   wire [4:0]  bus_fidx = waddr[6:2];
   wire [31:0] m_file   = strb_merge({24'h0, file_ff[bus_fidx]},
                                     wdat, wstb);
   wire bad_clr = wr_ok && hw_cstat && wstb[0] &&
                  wdat[bcis_pkg::CS_BAD];

   ////////////////////////////////////////////////////////////////////
   // execution datapath
   bcis_decode u_decode (
      .instr (instr_ff),
      .dec   (dec)
   );

   wire          exec    = state_ff == bcis_pkg::S_EXEC;
   wire [7:0]    f_val   = file_ff[dec.fidx];
   wire [7:0]    and_res = acc_ff & f_val;
   wire          f_bit   = f_val[dec.bsel];
   wire [PW-1:0] pc_inc  = pc_ff + bcis_pkg::PC_ONE;
   wire skip_hit = (dec.op == bcis_pkg::OP_BTZ && !f_bit) ||
                   (dec.op == bcis_pkg::OP_BTO && f_bit);
   wire do_call  = exec && dec.op == bcis_pkg::OP_CALL;
   wire kick     = exec && dec.op == bcis_pkg::OP_KICK;
   wire psa      = option_ff[bcis_pkg::OPT_PSA];
   // call target built from page bits as they stand now
   wire [PW-1:0] call_pc = {status_ff[bcis_pkg::ST_PA_HI:bcis_pkg::ST_PA_LO],
                            1'b0, dec.lit};

   bcis_stack #(
      .DEPTH (STACK_DEPTH),
      .W     (PW)
   ) u_stack (
      .aclk      (aclk),
      .aresetn   (aresetn),
      .push      (do_call),
      .push_data (pc_inc),
      .top       (stack_top)
   );

   // one write port on the file array, exec and bus never overlap
   wire       ex_fwr  = exec && dec.op == bcis_pkg::OP_AND && dec.dest;
   wire       file_we = ex_fwr || (wr_ok && hw_file);
   wire [4:0] file_wi = ex_fwr ? dec.fidx : bus_fidx;
   wire [7:0] file_wd = ex_fwr ? and_res : m_file[7:0];

   ////////////////////////////////////////////////////////////////////
   // watchdog counter and shared prescaler
   wire psc_carry = psc_ff == bcis_pkg::BYTE_ONES;
   wire wdt_step  = psa ? psc_carry : 1'b1;
   wire wdt_wrap  = wdt_step && wdt_ff == bcis_pkg::BYTE_ONES && !kick;
   wire [7:0] nxt_psc = (kick && psa) ? bcis_pkg::BYTE_ZERO
                                      : 8'(psc_ff + 8'h01);
   wire [7:0] nxt_wdt = kick ? bcis_pkg::BYTE_ZERO
                             : 8'(wdt_ff + {7'h00, wdt_step});

   ////////////////////////////////////////////////////////////////////
   // next-state of the architectural registers
   always_comb begin
      nxt_state  = state_ff;
      nxt_acc    = acc_ff;
      nxt_status = status_ff;
      nxt_pc     = pc_ff;
      case (state_ff)
         bcis_pkg::S_IDLE: begin
            if (instr_go) nxt_state = bcis_pkg::S_EXEC;
            if (wr_ok && hw_acc) nxt_acc = m_acc[7:0];
            if (wr_ok && hw_status) nxt_status = m_status[7:0];
            if (wr_ok && hw_pc) nxt_pc = m_pc[PW-1:0];
         end
         bcis_pkg::S_EXEC: begin
            nxt_state = bcis_pkg::S_IDLE;
            nxt_pc    = pc_inc;
            case (dec.op)
               bcis_pkg::OP_AND: begin
                  if (!dec.dest) nxt_acc = and_res;
                  nxt_status[bcis_pkg::ST_Z] = and_res == bcis_pkg::BYTE_ZERO;
               end
               bcis_pkg::OP_BTZ,
               bcis_pkg::OP_BTO: begin
                  // not taken ends here in one cycle
                  if (skip_hit) nxt_state = bcis_pkg::S_SKIP;
               end
               bcis_pkg::OP_CLRA: begin
                  nxt_acc = bcis_pkg::BYTE_ZERO;
                  nxt_status[bcis_pkg::ST_Z] = 1'b1;
               end
               bcis_pkg::OP_CALL: begin
                  nxt_pc    = call_pc;
                  nxt_state = bcis_pkg::S_CALL;
               end
               bcis_pkg::OP_KICK: begin
                  nxt_status[bcis_pkg::ST_TO] = 1'b1;
                  nxt_status[bcis_pkg::ST_PWRDN] = 1'b1;
               end
               default: begin
               end
            endcase
         end
         // discarded prefetch runs as a no-op
         bcis_pkg::S_SKIP: begin
            nxt_pc    = pc_inc;
            nxt_state = bcis_pkg::S_IDLE;
         end
         // second call cycle, flags untouched
         bcis_pkg::S_CALL: nxt_state = bcis_pkg::S_IDLE;
         default: nxt_state = bcis_pkg::S_IDLE;
      endcase
      if (wdt_wrap) nxt_status[bcis_pkg::ST_TO] = 1'b0;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state_ff  <= bcis_pkg::S_IDLE;
         acc_ff    <= bcis_pkg::BYTE_ZERO;
         status_ff <= bcis_pkg::STATUS_RST;
         pc_ff     <= bcis_pkg::PC_RST;
      end else begin
         state_ff  <= nxt_state;
         acc_ff    <= nxt_acc;
         status_ff <= nxt_status;
         pc_ff     <= nxt_pc;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         instr_ff  <= bcis_pkg::OPC_NOP;
         option_ff <= bcis_pkg::OPTION_RST;
         wdt_ff    <= bcis_pkg::BYTE_ZERO;
         psc_ff    <= bcis_pkg::BYTE_ZERO;
         bad_ff    <= 1'b0;
      end else begin
         if (instr_go) instr_ff <= m_instr[11:0];
         if (wr_ok && hw_option) option_ff <= m_option[7:0];
         wdt_ff <= nxt_wdt;
         psc_ff <= nxt_psc;
         // a new unsupported word wins over the clear
         bad_ff <= (exec && dec.op == bcis_pkg::OP_BAD) ||
                   (bad_ff && !bad_clr);
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         for (int i = 0; i < bcis_pkg::NFILE; i++) begin
            file_ff[i] <= bcis_pkg::BYTE_ZERO;
         end
      end else if (file_we) begin
         file_ff[file_wi] <= file_wd;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // write address/data holding and response
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held_ff <= 1'b0;
         w_held_ff  <= 1'b0;
         awaddr_ff  <= '0;
         wdata_ff   <= 32'h0000_0000;
         wstrb_ff   <= 4'h0;
         bvalid_ff  <= 1'b0;
         bresp_ff   <= bcis_pkg::RESP_OKAY;
      end else begin
         if (aw_take) awaddr_ff <= s_axi_awaddr;
         if (w_take) begin
            wdata_ff <= s_axi_wdata;
            wstrb_ff <= s_axi_wstrb;
         end
         if (wr_do) begin
            aw_held_ff <= 1'b0;
            w_held_ff  <= 1'b0;
            bvalid_ff  <= 1'b1;
            bresp_ff   <= wr_ok ? bcis_pkg::RESP_OKAY
                                : bcis_pkg::RESP_SLVERR;
         end else begin
            if (aw_take) aw_held_ff <= 1'b1;
            if (w_take) w_held_ff <= 1'b1;
            if (bvalid_ff && s_axi_bready) bvalid_ff <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////
   // read channel
   assign s_axi_arready = !rvalid_ff;
   assign s_axi_rvalid  = rvalid_ff;
   assign s_axi_rdata   = rdata_ff;
   assign s_axi_rresp   = rresp_ff;

   wire ar_take = s_axi_arvalid && s_axi_arready;
   wire [ADDR_W-1:0] ra = s_axi_araddr;
   wire [7:0] cstat = {6'h00, bad_ff, busy};
   wire r_file = is_file(ra);
   wire r_hit  = r_file || ra == bcis_pkg::A_INSTR ||
                 ra == bcis_pkg::A_ACC || ra == bcis_pkg::A_STATUS ||
                 ra == bcis_pkg::A_PC || ra == bcis_pkg::A_CSTAT ||
                 ra == bcis_pkg::A_OPTION || ra == bcis_pkg::A_WDT ||
                 ra == bcis_pkg::A_PSC || ra == bcis_pkg::A_STACK;
   wire [31:0] rd_mux =
      r_file                     ? {24'h0, file_ff[ra[6:2]]} :
      ra == bcis_pkg::A_INSTR    ? {20'h0, instr_ff}  :
      ra == bcis_pkg::A_ACC      ? {24'h0, acc_ff}    :
      ra == bcis_pkg::A_STATUS   ? {24'h0, status_ff} :
      ra == bcis_pkg::A_PC       ? {21'h0, pc_ff}     :
      ra == bcis_pkg::A_CSTAT    ? {24'h0, cstat}     :
      ra == bcis_pkg::A_OPTION   ? {24'h0, option_ff} :
      ra == bcis_pkg::A_WDT      ? {24'h0, wdt_ff}    :
      ra == bcis_pkg::A_PSC      ? {24'h0, psc_ff}    :
      ra == bcis_pkg::A_STACK    ? {21'h0, stack_top} : 32'h0000_0000;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rvalid_ff <= 1'b0;
         rdata_ff  <= 32'h0000_0000;
         rresp_ff  <= bcis_pkg::RESP_OKAY;
      end else if (ar_take) begin
         rvalid_ff <= 1'b1;
         rdata_ff  <= rd_mux;
         rresp_ff  <= r_hit ? bcis_pkg::RESP_OKAY : bcis_pkg::RESP_SLVERR;
      end else if (rvalid_ff && s_axi_rready) begin
         rvalid_ff <= 1'b0;
      end
   end
endmodule
`default_nettype wire

// file: pkg/bcis_pkg.sv
/*
 * bcis_pkg: shared constants, types and register map of the
 * instruction-subset core.
 * Assumes: a 12-bit instruction word, an 11-bit program counter.
 */
`default_nettype none
package bcis_pkg;
   // byte addresses on the register bus
   localparam logic [7:0] A_INSTR  = 8'h00;
   localparam logic [7:0] A_ACC    = 8'h04;
   localparam logic [7:0] A_STATUS = 8'h08;
   localparam logic [7:0] A_PC     = 8'h0C;
   localparam logic [7:0] A_CSTAT  = 8'h10;
   localparam logic [7:0] A_OPTION = 8'h14;
   localparam logic [7:0] A_WDT    = 8'h18;
   localparam logic [7:0] A_PSC    = 8'h1C;
   localparam logic [7:0] A_STACK  = 8'h20;
   localparam logic [7:0] A_FILE   = 8'h80;
   localparam int FILE_MSB = 7;
   ////////////////////////////////////////////////////////////////////
   localparam int PC_W      = 11;
   localparam int IW        = 12;
   localparam int NFILE     = 32;
   localparam int ST_Z      = 2;
   localparam int ST_PWRDN  = 3;
   localparam int ST_TO     = 4;
   localparam int ST_PA_LO  = 5;
   localparam int ST_PA_HI  = 6;
   localparam int CS_BUSY   = 0;
   localparam int CS_BAD    = 1;
   localparam int OPT_PSA   = 3;
   localparam logic [7:0] STATUS_RST = 8'h18;
   localparam logic [7:0] OPTION_RST = 8'hFF;
   localparam logic [7:0] BYTE_ZERO  = 8'h00;
   localparam logic [7:0] BYTE_ONES  = 8'hFF;
   localparam logic [PC_W-1:0] PC_RST = 11'h7FF;
   localparam logic [PC_W-1:0] PC_ONE = 11'h001;
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   ////////////////////////////////////////////////////////////////////
   localparam logic [5:0]    PFX_AND    = 6'h05;
   localparam logic [3:0]    PFX_BTZ    = 4'h6;
   localparam logic [3:0]    PFX_BTO    = 4'h7;
   localparam logic [3:0]    PFX_CALL   = 4'h9;
   localparam logic [IW-1:0] OPC_NOP    = 12'h000;
   localparam logic [IW-1:0] OPC_KICK   = 12'h004;
   localparam logic [IW-1:0] OPC_CLRACC = 12'h040;

   typedef enum logic [2:0] {
      OP_NOP  = 3'b000,
      OP_AND  = 3'b001,
      OP_BTZ  = 3'b010,
      OP_BTO  = 3'b011,
      OP_CLRA = 3'b100,
      OP_CALL = 3'b101,
      OP_KICK = 3'b110,
      OP_BAD  = 3'b111
   } bcis_op_t;

   typedef struct packed {
      bcis_op_t   op;
      logic [4:0] fidx;
      logic [2:0] bsel;
      logic       dest;
      logic [7:0] lit;
   } bcis_dec_t;

   typedef enum logic [1:0] {
      S_IDLE = 2'b00,
      S_EXEC = 2'b01,
      S_SKIP = 2'b10,
      S_CALL = 2'b11
   } bcis_state_t;
endpackage
`default_nettype wire

// file: rtl/bcis_decode.sv
/*
 * bcis_decode: splits a 12-bit instruction word into operation and
 * operand fields.
 * Assumes: purely combinational use inside the core.
 */
`timescale 1ns/1ps
`default_nettype none
module bcis_decode (
   input  wire logic [11:0]      instr,
   output bcis_pkg::bcis_dec_t   dec
);
   wire is_and  = instr[11:6] == bcis_pkg::PFX_AND;
   wire is_btz  = instr[11:8] == bcis_pkg::PFX_BTZ;
   wire is_bto  = instr[11:8] == bcis_pkg::PFX_BTO;
   wire is_call = instr[11:8] == bcis_pkg::PFX_CALL;
   wire is_clra = instr == bcis_pkg::OPC_CLRACC;
   wire is_kick = instr == bcis_pkg::OPC_KICK;
   wire is_nop  = instr == bcis_pkg::OPC_NOP;

   assign dec.op = is_and  ? bcis_pkg::OP_AND  :
                   is_btz  ? bcis_pkg::OP_BTZ  :
                   is_bto  ? bcis_pkg::OP_BTO  :
                   is_call ? bcis_pkg::OP_CALL :
                   is_clra ? bcis_pkg::OP_CLRA :
                   is_kick ? bcis_pkg::OP_KICK :
                   is_nop  ? bcis_pkg::OP_NOP  : bcis_pkg::OP_BAD;
   assign dec.fidx = instr[4:0];
   assign dec.dest = instr[5];
   assign dec.bsel = instr[7:5];
   assign dec.lit  = instr[7:0];
endmodule
`default_nettype wire

// file: rtl/bcis_stack.sv
/*
 * bcis_stack: hardware return stack, push only, shift organised.
 * Assumes: DEPTH of two or more; the oldest entry falls off the end.
 */
`timescale 1ns/1ps
`default_nettype none
module bcis_stack #(
   parameter int DEPTH = 2,
   parameter int W     = 11
) (
   input  wire logic         aclk,
   input  wire logic         aresetn,
   input  wire logic         push,
   input  wire logic [W-1:0] push_data,
   output logic      [W-1:0] top
);
   logic [W-1:0] slot_ff [DEPTH];

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         for (int i = 0; i < DEPTH; i++) slot_ff[i] <= '0;
      end else if (push) begin
         slot_ff[0] <= push_data;
         for (int i = 1; i < DEPTH; i++) slot_ff[i] <= slot_ff[i-1];
      end
   end

   assign top = slot_ff[0];
endmodule
`default_nettype wire

// file: dv/bcis_core_properties.sv
/* bcis_core_properties: bus and result checks bound to the core.
   Assumes: one clock; reads and writes of the bench never overlap. */
`timescale 1ns/1ps
`default_nettype none
module bcis_core_properties #(
   parameter int ADDR_W = 8
) (
   input wire logic              aclk,
   input wire logic              aresetn,
   input wire logic [ADDR_W-1:0] s_axi_awaddr,
   input wire logic              s_axi_awvalid,
   input wire logic              s_axi_awready,
   input wire logic [31:0]       s_axi_wdata,
   input wire logic              s_axi_wvalid,
   input wire logic              s_axi_wready,
   input wire logic [1:0]        s_axi_bresp,
   input wire logic              s_axi_bvalid,
   input wire logic              s_axi_bready,
   input wire logic [ADDR_W-1:0] s_axi_araddr,
   input wire logic              s_axi_arvalid,
   input wire logic              s_axi_arready,
   input wire logic [31:0]       s_axi_rdata,
   input wire logic [1:0]        s_axi_rresp,
   input wire logic              s_axi_rvalid,
   input wire logic              s_axi_rready
);
   logic [ADDR_W-1:0] aw_q, ar_q, lw_a;
   logic [31:0]       wd_q;
   logic [11:0]       lw_d;
   logic [1:0]        page;
   wire rd      = s_axi_rvalid && s_axi_rready && !s_axi_rresp[1];
   wire is_ins  = lw_a == bcis_pkg::A_INSTR;
   wire is_clr  = is_ins && lw_d == bcis_pkg::OPC_CLRACC;
   wire is_kick = is_ins && lw_d == bcis_pkg::OPC_KICK;
   wire is_call = is_ins && lw_d[11:8] == bcis_pkg::PFX_CALL;
   ////////////////////////////////////////////////////////////////////
   // last accepted write and the page bits it left behind
   always_ff @(posedge aclk) begin
      if (s_axi_awvalid && s_axi_awready) aw_q <= s_axi_awaddr;
      if (s_axi_wvalid && s_axi_wready) wd_q <= s_axi_wdata;
      if (s_axi_arvalid && s_axi_arready) ar_q <= s_axi_araddr;
   end
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         lw_a <= {ADDR_W{1'b1}};
         page <= 2'h0;
      end else if (s_axi_bvalid && s_axi_bready && !s_axi_bresp[1]) begin
         lw_a <= aw_q;
         lw_d <= wd_q[11:0];
         if (aw_q == bcis_pkg::A_STATUS) page <= wd_q[6:5];
      end
   end
   ////////////////////////////////////////////////////////////////////
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   a_clr_acc_zero: assert property (
      rd && is_clr && ar_q == bcis_pkg::A_ACC |-> s_axi_rdata == 32'h0)
      else $error("accumulator not zero after clear");
   a_clr_z_set: assert property (
      rd && is_clr && ar_q == bcis_pkg::A_STATUS |-> s_axi_rdata[2])
      else $error("zero flag not set after clear");
   a_kick_flags: assert property (
      rd && is_kick && ar_q == bcis_pkg::A_STATUS
      |-> s_axi_rdata[4:3] == 2'h3)
      else $error("low-active flags not set after kick");
   a_call_target: assert property (
      rd && is_call && ar_q == bcis_pkg::A_PC
      |-> s_axi_rdata[10:0] == {page, 1'b0, lw_d[7:0]})
      else $error("call target wrong");
   a_write_answer: assert property (s_axi_awvalid && s_axi_awready
      && s_axi_wvalid && s_axi_wready |=> s_axi_bvalid)
      else $error("write response late");
   a_read_answer: assert property (
      s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read response late");
   a_b_single: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
      else $error("write response repeated");
   a_r_single: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
      else $error("read response repeated");
   c_call: cover property (rd && is_call && ar_q == bcis_pkg::A_PC);
   c_clr: cover property (rd && is_clr && ar_q == bcis_pkg::A_ACC);
   c_kick: cover property (rd && is_kick && ar_q == bcis_pkg::A_STATUS);
endmodule
bind bcis_core bcis_core_properties #(.ADDR_W(ADDR_W)) bcis_core_properties_i (
   .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
   .s_axi_wdata, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
   .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
   .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
`default_nettype wire

// file: dv/bcis_core_bench.sv
/* bcis_core_bench: self-checking bench of the instruction-subset core.
   Assumes: the property checker is compiled and bound beside it. */
`timescale 1ns/1ps
`default_nettype none
`define CHK(gv, ev) begin checks_done++; if ((gv) !== (ev)) begin \
   err_total++; $display("ERROR %0t: got %h exp %h", $time, gv, ev); end end
module bcis_core_bench;
   logic        aclk, aresetn, awvalid, wvalid, bvalid, bready;
   logic        arvalid, arready, rvalid, rready, awready, wready;
   logic [7:0]  awaddr, araddr;
   logic [31:0] wdata, rdata;
   logic [1:0]  bresp, rresp, eb;
   logic [65:0] rq[$], e;
   logic [1:0]  bq[$];
   int          err_total = 0, checks_done = 0, cyc = 0;
   bcis_core bcis_core_i (
      .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
      .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
      .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arprot(3'h0),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
      .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
   initial begin
      aclk = 1'b0;
      forever #25 aclk = ~aclk;
   end
   ////////////////////////////////////////////////////////////////////
   task automatic final_report();
      $display("checks %0d mismatches %0d", checks_done, err_total);
      if (err_total == 0 && checks_done > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   always @(posedge aclk) begin
      cyc <= cyc + 1;
      if (cyc == 6000) begin
         err_total++;
         final_report();
      end
   end
   // monitor: oldest note against each answer
   always @(posedge aclk) begin
      if (rvalid && rready) begin
         e = rq.pop_front();
         `CHK({rresp, rdata & e[63:32]}, {e[65:64], e[31:0]})
      end
      if (bvalid && bready) begin
         eb = bq.pop_front();
         `CHK(bresp, eb)
      end
   end
   ////////////////////////////////////////////////////////////////////
   task automatic wr(input logic [7:0] a, input logic [31:0] d,
                     input logic [1:0] r = bcis_pkg::RESP_OKAY);
      @(posedge aclk);
      bq.push_back(r);
      awaddr  <= a;
      wdata   <= d;
      awvalid <= 1'b1;
      wvalid  <= 1'b1;
      bready  <= 1'b1;
      do begin
         @(posedge aclk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
      end while (!bvalid);
      bready <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] x,
                     input logic [31:0] m = 32'hFFFFFFFF,
                     input logic [1:0] r = bcis_pkg::RESP_OKAY);
      @(posedge aclk);
      rq.push_back({r, m, x & m});
      araddr  <= a;
      arvalid <= 1'b1;
      rready  <= 1'b1;
      do begin
         @(posedge aclk);
         if (arready) arvalid <= 1'b0;
      end while (!rvalid);
      rready <= 1'b0;
   endtask
   task automatic ex(input logic [11:0] i);
      wr(bcis_pkg::A_INSTR, {20'h00000, i});
      repeat (3) @(posedge aclk);
   endtask
   function automatic logic [7:0] fa(input logic [4:0] f);
      return bcis_pkg::A_FILE + {1'b0, f, 2'b00};
   endfunction
   ////////////////////////////////////////////////////////////////////
   initial begin
      logic [7:0]  a, v, r, s, l;
      logic [10:0] p;
      logic [4:0]  f;
      logic        t;
      aresetn <= 1'b0;
      {awvalid, wvalid, bready, arvalid, rready} <= 5'h00;
      {awaddr, araddr, wdata} <= 48'h0;
      void'($urandom(32'h91182346));
      repeat (8) @(posedge aclk);
      aresetn <= 1'b1;
      rd(bcis_pkg::A_STATUS, {24'h0, bcis_pkg::STATUS_RST});
      rd(bcis_pkg::A_PC, {21'h0, bcis_pkg::PC_RST});
      rd(8'h44, 32'h0, 32'hFFFFFFFF, bcis_pkg::RESP_SLVERR);
      wr(bcis_pkg::A_WDT, 32'h1, bcis_pkg::RESP_SLVERR);
      $display("reset and map test done");
      for (int k = 0; k < 4; k++) begin
         f = (k == 0) ? 5'h1F : 5'($urandom);
         a = 8'($urandom) | 8'h01;
         v = (k == 1) ? ~a : 8'($urandom);
         r = a & v;
         s = {1'b0, 2'(k), 2'h3, r != 8'h00, 2'h0};
         wr(bcis_pkg::A_STATUS, {24'h0, s});
         wr(bcis_pkg::A_ACC, {24'h0, a});
         wr(fa(f), {24'h0, v});
         ex({bcis_pkg::PFX_AND, k[0], f});
         rd(bcis_pkg::A_ACC, {24'h0, k[0] ? a : r});
         rd(fa(f), {24'h0, k[0] ? r : v});
         rd(bcis_pkg::A_STATUS, {24'h0, s[7:3], r==8'h0, 2'h0});
      end
      $display("and test done");
      for (int k = 0; k < 16; k++) begin
         f = 5'($urandom);
         v = 8'($urandom);
         v[k[2:0]] = k[0] ^ k[1];
         t = v[k[2:0]] ^ !k[3];
         s = 8'($urandom) & 8'h7C;
         p = 11'($urandom);
         wr(bcis_pkg::A_STATUS, {24'h0, s});
         wr(bcis_pkg::A_PC, {21'h0, p});
         wr(fa(f), {24'h0, v});
         ex({k[3] ? bcis_pkg::PFX_BTO : bcis_pkg::PFX_BTZ, k[2:0], f});
         rd(bcis_pkg::A_PC, {21'h0, 11'(p+11'h001+t)});
         rd(bcis_pkg::A_STATUS, {24'h0, s});
      end
      $display("bit test done");
      wr(bcis_pkg::A_ACC, 32'h5A);
      wr(bcis_pkg::A_STATUS, 32'h38);
      ex(bcis_pkg::OPC_CLRACC);
      rd(bcis_pkg::A_ACC, 32'h0);
      rd(bcis_pkg::A_STATUS, 32'h3C);
      $display("clear test done");
      for (int k = 0; k < 4; k++) begin
         l = (k == 0) ? 8'h00 : (k == 1) ? 8'hFF : 8'($urandom);
         p = 11'($urandom) | 11'h100;
         s = {1'b0, 2'(k), 5'h18};
         wr(bcis_pkg::A_STATUS, {24'h0, s});
         wr(bcis_pkg::A_PC, {21'h0, p});
         ex({bcis_pkg::PFX_CALL, l});
         rd(bcis_pkg::A_PC, {21'h0, 2'(k), 1'b0, l});
         rd(bcis_pkg::A_STACK, {21'h0, 11'(p + 11'h001)});
         rd(bcis_pkg::A_STATUS, {24'h0, s});
      end
      $display("call test done");
      for (int k = 0; k < 2; k++) begin
         wr(bcis_pkg::A_OPTION, k ? 32'hF7 : 32'hFF);
         wr(bcis_pkg::A_STATUS, 32'h0);
         while (cyc[7:0] != (k ? 8'h08 : 8'h88)) @(posedge aclk);
         ex(bcis_pkg::OPC_KICK);
         rd(bcis_pkg::A_STATUS, 32'h18, 32'h18);
         rd(bcis_pkg::A_WDT, 32'h0, k ? 32'hF0 : 32'hFF);
         rd(bcis_pkg::A_PSC, k?32'h80:32'h0, k?32'hC0:32'hF0);
      end
      $display("watchdog test done");
      final_report();
   end
endmodule
`default_nettype wire
